// [design/pie_irq_enable_bank.sv]
// Peripheral interrupt enable bank with APB register access, source flags,
// group and global gating, and a block interrupt for software.
// Assumes source events are one-cycle pulses from logic on pclk.
`timescale 1ns/1ps
`default_nettype none

module pie_irq_enable_bank (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral source events.
   input wire pie_pkg::pie_bank_t src_event,
   // Requests toward the core.
   output logic periph_req,
   output logic core_irq_req,
   // Block interrupt for software.
   output logic irq
);
   import pie_pkg::*;

   localparam logic [2:0][7:0] BANK_IMPL = {PIE_IMPL_C, PIE_IMPL_B, PIE_IMPL_A};
   localparam logic [2:0][7:0] EN_OFS = {PIE_OFS_EN_C, PIE_OFS_EN_B, PIE_OFS_EN_A};
   localparam logic [2:0][7:0] FLAG_OFS = {PIE_OFS_FLAG_C, PIE_OFS_FLAG_B, PIE_OFS_FLAG_A};

   logic [2:0][7:0] en_v;
   logic [2:0][7:0] flag_v;
   logic [2:0][7:0] ev_v;
   pie_bank_t en_q;
   pie_bank_t flag_q;
   logic [7:0] core_q;
   logic [7:0] stat_q;
   logic [7:0] mask_q;
   logic [7:0] stat_set;
   logic global_irq_enable;
   logic periph_group_enable;
   logic acc;
   logic wr;
   logic setup;
   logic mapped;
   logic [7:0] rd_byte;
   logic req_prev_reg;
   logic [31:0] prdata_reg;

   // Bus phase decode; the slave never inserts wait states.
   assign setup = psel && !penable;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign pready = 1'b1;

   // Address map decode.
   always_comb begin
      case (paddr)
         PIE_OFS_EN_A, PIE_OFS_EN_B, PIE_OFS_EN_C, PIE_OFS_CORE,
         PIE_OFS_FLAG_A, PIE_OFS_FLAG_B, PIE_OFS_FLAG_C,
         PIE_OFS_IRQ_STAT, PIE_OFS_IRQ_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Unmapped accesses answer with an error and change only the error status bit.
   assign pslverr = acc && !mapped;

   // Bank views; each enable bit lines up with its source's flag bit.
   // gate and converter
   assign ev_v = src_event;
   assign en_q = en_v;
   assign flag_q = flag_v;

   // Enable and flag registers for the three banks.
   for (genvar g = 0; g < 3; g++) begin : g_bank
      pie_reg8 #(.IMPL(BANK_IMPL[g]), .W1C(1'b0)) u_en (
         .pclk(pclk),
         .presetn(presetn),
         .wr_en(wr && paddr == EN_OFS[g]),
         .wdata(pwdata[7:0]),
         .set(PIE_RST_BYTE),
         .q(en_v[g])
      );
      pie_reg8 #(.IMPL(BANK_IMPL[g]), .W1C(1'b1)) u_flag (
         .pclk(pclk),
         .presetn(presetn),
         .wr_en(wr && paddr == FLAG_OFS[g]),
         .wdata(pwdata[7:0]),
         .set(ev_v[g]),
         .q(flag_v[g])
      );
   end

   // Core control register holding the global and group enables.
   pie_reg8 #(.IMPL(PIE_IMPL_CORE), .W1C(1'b0)) u_core (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr && paddr == PIE_OFS_CORE),
      .wdata(pwdata[7:0]),
      .set(PIE_RST_BYTE),
      .q(core_q)
   );

   assign global_irq_enable = core_q[PIE_CORE_GLOBAL_BIT];
   assign periph_group_enable = core_q[PIE_CORE_GROUP_BIT];

   assign periph_req = periph_group_enable && (|(flag_q & en_q));

   assign core_irq_req = global_irq_enable && periph_req;

   // Previous request level, used to spot a new request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_prev_reg <= 1'b0;
      end else begin
         req_prev_reg <= periph_req;
      end
   end

   // Block events: a new peripheral request and a bus error.
   always_comb begin
      stat_set = PIE_RST_BYTE;
      stat_set[PIE_ST_REQ_BIT] = periph_req && !req_prev_reg;
      stat_set[PIE_ST_ERR_BIT] = pslverr;
   end

   // Sticky status, cleared by writing one.
   pie_reg8 #(.IMPL(PIE_IMPL_IRQ), .W1C(1'b1)) u_stat (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr && paddr == PIE_OFS_IRQ_STAT),
      .wdata(pwdata[7:0]),
      .set(stat_set),
      .q(stat_q)
   );

   // Mask with the status layout.
   pie_reg8 #(.IMPL(PIE_IMPL_IRQ), .W1C(1'b0)) u_mask (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr && paddr == PIE_OFS_IRQ_MASK),
      .wdata(pwdata[7:0]),
      .set(PIE_RST_BYTE),
      .q(mask_q)
   );

   // Level interrupt while any unmasked status bit is set.
   assign irq = |(stat_q & mask_q);

   // Read multiplexer; unimplemented bits are already zero in storage.
   always_comb begin
      case (paddr)
         PIE_OFS_EN_A: rd_byte = en_v[0];
         PIE_OFS_EN_B: rd_byte = en_v[1];
         PIE_OFS_EN_C: rd_byte = en_v[2] & PIE_IMPL_C;
         PIE_OFS_CORE: rd_byte = core_q;
         PIE_OFS_FLAG_A: rd_byte = flag_v[0];
         PIE_OFS_FLAG_B: rd_byte = flag_v[1];
         PIE_OFS_FLAG_C: rd_byte = flag_v[2];
         PIE_OFS_IRQ_STAT: rd_byte = stat_q;
         PIE_OFS_IRQ_MASK: rd_byte = mask_q;
         default: rd_byte = PIE_RST_BYTE;
      endcase
   end

   // Read data is captured in the setup cycle and held through access.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= {PIE_RD_PAD, PIE_RST_BYTE};
      end else if (setup && !pwrite) begin
         prdata_reg <= {PIE_RD_PAD, rd_byte};
      end
   end

   assign prdata = prdata_reg;

   // Checks on the register behaviour and the request path.
   sequence s_setup(logic [7:0] ofs);
      psel && !penable && pwrite && paddr == ofs;
   endsequence

   sequence s_access(logic [7:0] ofs);
      psel && penable && pwrite && paddr == ofs;
   endsequence

   AST_EN_PASSES: assert property (@(posedge pclk) disable iff (!presetn)
      (periph_group_enable && (|(flag_q & en_q))) |-> periph_req)
      else $error("Enabled flag did not raise the request.");

   AST_EN_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
      (en_q == '0) |-> !periph_req && !core_irq_req)
      else $error("Request passed with all enables clear.");

   AST_GROUP_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      !periph_group_enable |-> !periph_req)
      else $error("Request passed without the group enable.");

   AST_RESET_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      $past(!presetn) |-> en_q == '0 && core_q == PIE_RST_BYTE)
      else $error("Enables not zero after reset.");

   AST_WRITE_A: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup(PIE_OFS_EN_A) ##1 s_access(PIE_OFS_EN_A) |=> en_q.a == $past(pwdata[7:0]))
      else $error("First enable register did not take the write.");

   AST_WRITE_B: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup(PIE_OFS_EN_B) ##1 s_access(PIE_OFS_EN_B) |=> en_q.b == $past(pwdata[7:0]))
      else $error("Second enable register did not take the write.");

   AST_WRITE_C: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup(PIE_OFS_EN_C) ##1 s_access(PIE_OFS_EN_C)
      |=> en_q.c == ($past(pwdata[7:0]) & PIE_IMPL_C))
      else $error("Third enable register did not take the write.");

   AST_C_TOP_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == PIE_OFS_EN_C |=> prdata[7:6] == 2'h0)
      else $error("Unimplemented bits read nonzero.");

   AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
      (src_event != '0)
      |=> (flag_q & $past(src_event) & BANK_IMPL) == ($past(src_event) & BANK_IMPL))
      else $error("Source event lost its flag.");

   AST_GLOBAL_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      (!global_irq_enable |-> !core_irq_req)
      and (global_irq_enable && periph_req |-> core_irq_req))
      else $error("Core request disagrees with the global enable.");

   AST_REQ_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
      periph_req && !acc |=> periph_req)
      else $error("Request dropped without a register write.");

   AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      s_access(PIE_OFS_FLAG_A) ##0 (src_event.a == '0) |=> (flag_q.a & $past(pwdata[7:0])) == '0)
      else $error("Flag did not clear on a written one.");

   AST_C_UNUSED: assert property (@(posedge pclk) disable iff (!presetn)
      en_q.c.unused == 2'h0 && flag_q.c.unused == 2'h0)
      else $error("Unimplemented bits of the third register were set.");

   AST_REQ_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(periph_req) |=> stat_q[PIE_ST_REQ_BIT])
      else $error("New request did not set its status bit.");

   // A request that waited while the global enable was off, then sees it return.
   sequence s_pending_held;
      !global_irq_enable && periph_req ##1 global_irq_enable && periph_req;
   endsequence

   AST_PENDING_SERVED: assert property (@(posedge pclk) disable iff (!presetn)
      s_pending_held |-> core_irq_req)
      else $error("Pending request not passed once the global enable returned.");

endmodule // pie_irq_enable_bank

`default_nettype wire

// [design/pie_reg8.sv]
// One 8-bit register, either plain read/write or sticky write-one-to-clear.
// Assumes writes and sets arrive on pclk from logic in the same domain.
`timescale 1ns/1ps
`default_nettype none

module pie_reg8 #(
   parameter logic [7:0] IMPL = 8'hFF,
   parameter bit W1C = 1'b0
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Software write.
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   // Hardware set, used only in sticky mode.
   input wire logic [7:0] set,
   // Stored value.
   output logic [7:0] q
);
   import pie_pkg::*;

   logic [7:0] q_next;

   // Sticky mode lets a set beat a clear in the same cycle.
   always_comb begin
      if (W1C) begin
         q_next = ((q & ~(wr_en ? wdata : PIE_RST_BYTE)) | set) & IMPL;
      end else begin
         q_next = wr_en ? (wdata & IMPL) : q;
      end
   end

   // Storage; all resets clear it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= PIE_RST_BYTE;
      end else begin
         q <= q_next;
      end
   end

endmodule // pie_reg8

`default_nettype wire

// [shared/pie_pkg.sv]
// Package for the peripheral interrupt enable bank: register map,
// field layouts, reset values and the carrier types.
// Assumes a 32-bit APB with an 8-bit byte address.
`default_nettype none

package pie_pkg;

   // Register byte offsets.
   localparam logic [7:0] PIE_OFS_EN_A = 8'h00;
   localparam logic [7:0] PIE_OFS_EN_B = 8'h04;
   localparam logic [7:0] PIE_OFS_EN_C = 8'h08;
   localparam logic [7:0] PIE_OFS_CORE = 8'h0C;
   localparam logic [7:0] PIE_OFS_FLAG_A = 8'h10;
   localparam logic [7:0] PIE_OFS_FLAG_B = 8'h14;
   localparam logic [7:0] PIE_OFS_FLAG_C = 8'h18;
   localparam logic [7:0] PIE_OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] PIE_OFS_IRQ_MASK = 8'h20;

   // Implemented bits of each register; the rest read as zero.
   localparam logic [7:0] PIE_IMPL_A = 8'hFF;
   localparam logic [7:0] PIE_IMPL_B = 8'hFF;
   localparam logic [7:0] PIE_IMPL_C = 8'h3F;
   localparam logic [7:0] PIE_IMPL_CORE = 8'hC0;
   localparam logic [7:0] PIE_IMPL_IRQ = 8'h03;

   // Core control bit positions.
   localparam int PIE_CORE_GLOBAL_BIT = 7;
   localparam int PIE_CORE_GROUP_BIT = 6;

   // Block interrupt status bit positions.
   localparam int PIE_ST_REQ_BIT = 0;
   localparam int PIE_ST_ERR_BIT = 1;

   // Reset values.
   localparam logic [7:0] PIE_RST_BYTE = 8'h00;
   localparam logic [23:0] PIE_RD_PAD = 24'h000000;

   // First enable register layout.
   typedef struct packed {
      logic timer1_gate_en;
      logic adc_done_en;
      logic uart_rx_en;
      logic uart_tx_en;
      logic sync_serial_en;
      logic capcmp1_en;
      logic timer2_match_en;
      logic timer1_overflow_en;
   } pie_reg_a_t;

   // Second enable register layout.
   typedef struct packed {
      logic osc_fail_en;
      logic comparator2_en;
      logic comparator1_en;
      logic outgen1_shutdown_en;
      logic bus_collision_en;
      logic comparator4_en;
      logic comparator3_en;
      logic capcmp2_en;
   } pie_reg_b_t;

   // Third enable register layout.
   typedef struct packed {
      logic [1:0] unused;
      logic outgen2_shutdown_en;
      logic zero_cross_en;
      logic logic_cell4_en;
      logic logic_cell3_en;
      logic logic_cell2_en;
      logic logic_cell1_en;
   } pie_reg_c_t;

   // One bit per source across all three registers.
   typedef struct packed {
      pie_reg_c_t c;
      pie_reg_b_t b;
      pie_reg_a_t a;
   } pie_bank_t;

endpackage

`default_nettype wire

// [test/pie_src_model.sv]
// Model of the peripheral interrupt sources that face the enable bank.
// Assumes the bench asks for events on pclk through a valid strobe.
`timescale 1ns/1ps
`default_nettype none

module pie_src_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Request from the bench.
   input wire logic fire_valid,
   input wire logic [23:0] fire_bits,
   // Events toward the bank.
   output var pie_pkg::pie_bank_t src_event
);
   import pie_pkg::*;

   // Each request becomes a pulse of exactly one cycle, as real sources give.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_event <= 24'h000000;
      end else if (fire_valid) begin
         src_event <= fire_bits;
      end else begin
         src_event <= 24'h000000;
      end
   end
endmodule // pie_src_model

`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the peripheral interrupt enable bank.
// Assumes the bank answers APB with no wait states and sources pulse once.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import pie_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic fire_valid;
   logic [23:0] fire_bits, en;
   pie_bank_t src_event;
   logic periph_req, core_irq_req, irq;
   logic [32:0] exp_q[$];
   int n_errors = 0;
   int checks_done = 0;
   int i;

   pie_irq_enable_bank pie_irq_enable_bank_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_event(src_event), .periph_req(periph_req),
      .core_irq_req(core_irq_req), .irq(irq));
   pie_src_model pie_src_model_i (.pclk(pclk), .presetn(presetn), .fire_valid(fire_valid),
      .fire_bits(fire_bits), .src_event(src_event));

   // The clock toggles every 25 ns, a period of 50 ns.
   initial begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end

   task cmp_word(input string what, input logic [32:0] exp, input logic [32:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task cmp_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   // One APB transfer, held until pready is sampled high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'h1 && k < 50) begin
         @(posedge pclk);
         k++;
      end
      if (pready !== 1'h1) begin
         n_errors++;
         $display("ERROR apb pready expected 1 seen %b", pready);
      end
      psel <= 1'h0;
      penable <= 1'h0;
      #1;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   // A read notes its expected error flag and byte before it starts.
   task rd(input logic [7:0] a, input logic e, input logic [7:0] b);
      exp_q.push_back({e, 24'h000000, b});
      apb(1'h0, a, 32'h00000000);
   endtask

   task set_en(input logic [23:0] m);
      wr(PIE_OFS_EN_A, {24'h000000, m[7:0]});
      wr(PIE_OFS_EN_B, {24'h000000, m[15:8]});
      wr(PIE_OFS_EN_C, {24'h000000, m[23:16]});
   endtask

   task clr_flags;
      wr(PIE_OFS_FLAG_A, 32'h000000FF);
      wr(PIE_OFS_FLAG_B, 32'h000000FF);
      wr(PIE_OFS_FLAG_C, 32'h000000FF);
   endtask

   // Fires events, then waits until flags and requests have settled.
   task fire(input logic [23:0] b);
      @(posedge pclk);
      fire_valid <= 1'h1;
      fire_bits <= b;
      @(posedge pclk);
      fire_valid <= 1'h0;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task print_verdict;
      if (exp_q.size() != 0) begin
         n_errors++;
         $display("ERROR read queue expected empty seen %0d notes", exp_q.size());
      end
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Each completed read takes the oldest note off the queue and compares.
   always @(posedge pclk) begin
      if (presetn && psel && penable && pready === 1'h1 && !pwrite) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("ERROR read queue expected a note seen none");
         end else begin
            cmp_word("apb read", exp_q.pop_front(), {pslverr, prdata});
         end
      end
   end

   // A hang is cut short well after the tests should have ended.
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      print_verdict;
   end

   // Main sequence.
   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      fire_valid = 1'h0;
      fire_bits = 24'h000000;
      en = 24'($urandom(32'hBE5D734E));
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      for (i = 0; i < 9; i++) rd(8'(i * 4), 1'h0, 8'h00);
      rd(8'h24, 1'h1, 8'h00);
      repeat (4) begin
         en = 24'($urandom());
         set_en(en);
         rd(PIE_OFS_EN_A, 1'h0, en[7:0]);
         rd(PIE_OFS_EN_B, 1'h0, en[15:8]);
         rd(PIE_OFS_EN_C, 1'h0, en[23:16] & 8'h3F);
      end
      clr_flags;
      wr(PIE_OFS_CORE, 32'h000000C0);
      for (i = 0; i < 22; i++) begin
         en = 24'h000001 << i;
         set_en(en);
         fire(~en);
         cmp_bit("blocked source", 1'h0, periph_req);
         fire(en);
         cmp_bit("passed source", 1'h1, core_irq_req);
         clr_flags;
      end
      set_en(24'h000000);
      fire(24'hFFFFFF);
      cmp_bit("all disabled", 1'h0, periph_req);
      rd(PIE_OFS_FLAG_A, 1'h0, 8'hFF);
      rd(PIE_OFS_FLAG_C, 1'h0, 8'h3F);
      set_en(24'hFFFFFF);
      wr(PIE_OFS_CORE, 32'h00000080);
      cmp_bit("group off", 1'h0, periph_req);
      wr(PIE_OFS_CORE, 32'h00000040);
      cmp_bit("global off", 1'h0, core_irq_req);
      wr(PIE_OFS_CORE, 32'h000000C0);
      cmp_bit("global back on", 1'h1, core_irq_req);
      rd(PIE_OFS_IRQ_STAT, 1'h0, 8'h03);
      cmp_bit("masked irq", 1'h0, irq);
      wr(PIE_OFS_IRQ_MASK, 32'h00000001);
      cmp_bit("unmasked irq", 1'h1, irq);
      wr(PIE_OFS_IRQ_STAT, 32'h00000003);
      cmp_bit("cleared irq", 1'h0, irq);
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      rd(PIE_OFS_EN_B, 1'h0, 8'h00);
      cmp_bit("request after reset", 1'h0, core_irq_req);
      print_verdict;
   end
endmodule // testbench

`default_nettype wire
